// [twbmc_pkg.sv]
// Constants, timing figures and state codes for the two-wire bus master.
// Assumes a 25 MHz core clock; all bus timing is derived from it here.
package twbmc_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_FREQ_MHZ = 25;
  localparam int NS_PER_US    = 1000;
  // Half bit periods for the three bus rates, in ns
  localparam int HALF_100K_NS = 5000;
  localparam int HALF_250K_NS = 2000;
  localparam int HALF_400K_NS = 1250;
  // Least times, so rounded up to whole cycles
  localparam logic [7:0] HALF_100K_CYC =
    8'((HALF_100K_NS * CLK_FREQ_MHZ + NS_PER_US - 1) / NS_PER_US);
  localparam logic [7:0] HALF_250K_CYC =
    8'((HALF_250K_NS * CLK_FREQ_MHZ + NS_PER_US - 1) / NS_PER_US);
  localparam logic [7:0] HALF_400K_CYC =
    8'((HALF_400K_NS * CLK_FREQ_MHZ + NS_PER_US - 1) / NS_PER_US);
  localparam logic [7:0] CNT_STEP = 8'h01;

  // ----------------------------------------------------------------------
  // Rate codes, bit positions, direction
  // ----------------------------------------------------------------------
  localparam logic [1:0] RATE_100K    = 2'h0;
  localparam logic [1:0] RATE_250K    = 2'h1;
  localparam logic [1:0] RATE_400K    = 2'h2;
  localparam logic [3:0] FIRST_BIT    = 4'h0;
  localparam logic [3:0] LAST_BIT     = 4'h7;
  localparam logic [3:0] ACK_BIT      = 4'h8;
  localparam logic [3:0] BIT_STEP     = 4'h1;
  localparam logic       DIR_WRITE    = 1'b0;
  localparam logic       DIR_READ     = 1'b1;

  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_START_A = 4'h1,
    ST_START_B = 4'h2,
    ST_LOW     = 4'h3,
    ST_HIGH    = 4'h4,
    ST_LOAD    = 4'h5,
    ST_HOLD    = 4'h6,
    ST_RSTART  = 4'h7,
    ST_STOP_A  = 4'h8,
    ST_STOP_B  = 4'h9,
    ST_STOP_C  = 4'ha
  } twbmc_st_t;

endpackage

// [twbmc_master.sv]
// Two-wire bus master: task-driven sequencer, bit engine and pin routing.
// Assumes tasks are one-cycle pulses from logic on ref_clk_in, and that an
// external pad ring turns each enable into an open-drain pull-down.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Bus clock rate selectable among 100, 250 and 400 kbit/s.
// - Two open-drain lines, clock and data, wired-AND with the slaves.
// - Half duplex: master drives data or listens, never both at once.
// - Seven-bit slave address reaches up to 128 slaves.
// - Single master only; no arbitration is attempted.
// - Slave may hold clock low; master waits, then gives the full high half.
// - Begin tasks start an operation; the stop task ends it.
// - Stopped event raised once stop has taken effect and bus is idle.
// - Stop is not acted on while suspended; resume must come first.
// - Not-acknowledge sampled from the slave raises the error event.
// - Clock and data lines each routed to any pin, chosen independently.
// - After each start send address plus direction, write 0, read 1.
// - Receiving: acknowledge all bytes but the last, which gets NACK.
// - Final-transmit-byte event when sending of the last byte begins.
// - No self-halt on exhausted buffer or error; controller issues stop.
module twbmc_master #(
  parameter int PIN_COUNT = 32,
  parameter int COUNT_W   = 8,
  parameter int PSEL_W    = $clog2(PIN_COUNT)
) (
  // Clock, reset, enable
  input  wire logic                  ref_clk_in,
  input  wire logic                  arst_n_in,
  input  wire logic                  clk_en_in,
  // Tasks
  input  wire logic                  begin_transmit_task_in,
  input  wire logic                  begin_receive_task_in,
  input  wire logic                  stop_task_in,
  input  wire logic                  suspend_task_in,
  input  wire logic                  resume_task_in,
  // Configuration
  input  wire logic [1:0]            rate_sel_in,
  input  wire logic [6:0]            slave_addr_in,
  input  wire logic [COUNT_W-1:0]    tx_count_in,
  input  wire logic [COUNT_W-1:0]    rx_count_in,
  input  wire logic [PSEL_W-1:0]     scl_pin_sel_in,
  input  wire logic [PSEL_W-1:0]     sda_pin_sel_in,
  // Transmit byte stream
  input  wire logic [7:0]            tx_data_in,
  input  wire logic                  tx_valid_in,
  output logic                       tx_take_out,
  // Receive byte stream
  output logic      [7:0]            rx_data_out,
  output logic                       rx_valid_out,
  // Events
  output logic                       final_tx_byte_event_out,
  output logic                       final_rx_byte_event_out,
  output logic                       stopped_event_out,
  output logic                       error_event_out,
  output logic                       suspended_event_out,
  // General-purpose pins
  input  wire logic [PIN_COUNT-1:0]  pin_in,
  output logic      [PIN_COUNT-1:0]  pin_out,
  output logic      [PIN_COUNT-1:0]  pin_oe_out
);
  import twbmc_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  localparam logic [COUNT_W-1:0] REM_ONE  = COUNT_W'(1);
  localparam logic [COUNT_W-1:0] REM_NONE = '0;

  typedef struct packed {
    twbmc_st_t            st;
    logic [7:0]           cnt;
    logic [7:0]           shift;
    logic [3:0]           bit_cnt;
    logic [6:0]           addr;
    logic [1:0]           rate;
    logic [COUNT_W-1:0]   rem;
    logic                 is_rx;
    logic                 is_addr;
    logic                 stop_pend;
    logic                 susp;
    logic                 scl_low;
    logic                 sda_low;
    logic                 tx_take;
    logic [7:0]           rx_data;
    logic                 rx_valid;
    logic                 ev_final_tx;
    logic                 ev_final_rx;
    logic                 ev_stopped;
    logic                 ev_error;
    logic                 ev_susp;
    logic [PIN_COUNT-1:0] sync1;
    logic [PIN_COUNT-1:0] sync2;
    logic [PIN_COUNT-1:0] pin_drv;
    logic [PIN_COUNT-1:0] pin_oe;
  } twbmc_state_t;

  twbmc_state_t r;
  twbmc_state_t next_r;

  logic scl_s;
  logic sda_s;
  logic start_req;
  logic stop_eff;
  logic launch;
  logic [COUNT_W-1:0] rem_n;

  // Half bit period minus one, as loaded into the down counter
  function automatic logic [7:0] half_of(input logic [1:0] rate);
    case (rate)
      RATE_250K: half_of = HALF_250K_CYC - CNT_STEP;
      RATE_400K: half_of = HALF_400K_CYC - CNT_STEP;
      default:   half_of = HALF_100K_CYC - CNT_STEP;
    endcase
  endfunction

  // Sampled lines come from the second synchroniser stage only
  assign scl_s     = r.sync2[scl_pin_sel_in];
  assign sda_s     = r.sync2[sda_pin_sel_in];
  assign start_req = begin_transmit_task_in | begin_receive_task_in;
  assign stop_eff  = r.stop_pend | stop_task_in;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    next_r             = r;
    launch             = 1'b0;
    rem_n              = r.rem;
    next_r.tx_take     = 1'b0;
    next_r.rx_valid    = 1'b0;
    next_r.ev_final_tx = 1'b0;
    next_r.ev_final_rx = 1'b0;
    next_r.ev_stopped  = 1'b0;
    next_r.ev_error    = 1'b0;
    next_r.ev_susp     = 1'b0;
    next_r.sync1       = pin_in;
    next_r.sync2       = r.sync1;
    // Suspend beats a resume in the same cycle
    if (suspend_task_in) begin
      next_r.susp = 1'b1;
    end else if (resume_task_in) begin
      next_r.susp = 1'b0;
    end
    if (stop_task_in) begin
      next_r.stop_pend = 1'b1;
    end
    case (r.st)
      ST_IDLE: begin
        if (stop_eff) begin
          next_r.ev_stopped = 1'b1;
          next_r.stop_pend  = 1'b0;
        end else if (start_req) begin
          launch    = 1'b1;
          next_r.st = ST_START_A;
        end
      end
      ST_START_A: begin
        // Clock released; a held-low clock keeps us here
        if (scl_s) begin
          if (r.cnt != 8'h00) begin
            next_r.cnt = r.cnt - CNT_STEP;
          end else begin
            next_r.st  = ST_START_B;
            next_r.cnt = half_of(r.rate);
          end
        end
      end
      ST_START_B: begin
        next_r.sda_low = 1'b1; // Start: data falls while clock high
        if (r.cnt != 8'h00) begin
          next_r.cnt = r.cnt - CNT_STEP;
        end else begin
          next_r.st      = ST_LOW;
          next_r.scl_low = 1'b1;
          next_r.cnt     = half_of(r.rate);
          next_r.bit_cnt = FIRST_BIT;
          next_r.is_addr = 1'b1;
          next_r.shift   = {r.addr, r.is_rx};
        end
      end
      ST_LOW: begin
        // Data moves at least one cycle after the clock fell (two at a byte start after LOAD), never with it
        if (r.bit_cnt == ACK_BIT) begin
          next_r.sda_low = r.is_rx && !r.is_addr && (r.rem > REM_ONE);
        end else if (r.is_rx && !r.is_addr) begin
          next_r.sda_low = 1'b0;
        end else begin
          next_r.sda_low = !r.shift[7];
        end
        if (r.cnt != 8'h00) begin
          next_r.cnt = r.cnt - CNT_STEP;
        end else begin
          next_r.st      = ST_HIGH;
          next_r.scl_low = 1'b0;
          next_r.cnt     = half_of(r.rate);
        end
      end
      ST_HIGH: begin
        // Timing restarts only once the slave lets the clock rise
        if (scl_s && (r.cnt != 8'h00)) begin
          next_r.cnt = r.cnt - CNT_STEP;
        end else if (scl_s) begin
          next_r.scl_low = 1'b1;
          next_r.cnt     = half_of(r.rate);
          if (r.bit_cnt != ACK_BIT) begin
            next_r.shift   = {r.shift[6:0], sda_s};
            next_r.bit_cnt = r.bit_cnt + BIT_STEP;
            next_r.st      = ST_LOW;
          end else begin
            if ((!r.is_rx || r.is_addr) && sda_s) begin
              next_r.ev_error = 1'b1;
            end
            if (r.is_rx && !r.is_addr) begin
              next_r.rx_data  = r.shift;
              next_r.rx_valid = 1'b1;
              rem_n           = r.rem - REM_ONE;
              next_r.ev_final_rx = (rem_n == REM_ONE);
            end else if (r.is_addr && r.is_rx && (r.rem == REM_ONE)) begin
              next_r.ev_final_rx = 1'b1;
            end
            next_r.rem     = rem_n;
            next_r.is_addr = 1'b0;
            next_r.bit_cnt = FIRST_BIT;
            // Errors do not divert it; empty buffers and suspend leave the bus held, not released
            if (stop_eff && !r.susp) begin
              next_r.st = ST_STOP_A;
            end else if (r.susp || (rem_n == REM_NONE)) begin
              next_r.st      = ST_HOLD;
              next_r.ev_susp = r.susp;
            end else begin
              next_r.st = ST_LOAD;
            end
          end
        end
      end
      ST_LOAD: begin
        // Clock stays low while the byte source is not ready
        if (r.is_rx) begin
          next_r.st  = ST_LOW;
          next_r.cnt = half_of(r.rate);
        end else if (tx_valid_in) begin
          next_r.st          = ST_LOW;
          next_r.cnt         = half_of(r.rate);
          next_r.shift       = tx_data_in;
          next_r.tx_take     = 1'b1;
          next_r.rem         = r.rem - REM_ONE;
          next_r.ev_final_tx = (r.rem == REM_ONE);
        end
      end
      ST_HOLD: begin
        if (!r.susp) begin
          if (stop_eff) begin
            next_r.st  = ST_STOP_A;
            next_r.cnt = half_of(r.rate);
          end else if (start_req) begin
            launch    = 1'b1;
            next_r.st = ST_RSTART;
          end else if (r.rem != REM_NONE) begin
            next_r.st = ST_LOAD;
          end
        end
      end
      ST_RSTART: begin
        next_r.sda_low = 1'b0; // Free data under a low clock first
        if (r.cnt != 8'h00) begin
          next_r.cnt = r.cnt - CNT_STEP;
        end else begin
          next_r.st      = ST_START_A;
          next_r.scl_low = 1'b0;
          next_r.cnt     = half_of(r.rate);
        end
      end
      ST_STOP_A: begin
        next_r.sda_low = 1'b1;
        if (r.cnt != 8'h00) begin
          next_r.cnt = r.cnt - CNT_STEP;
        end else begin
          next_r.st      = ST_STOP_B;
          next_r.scl_low = 1'b0;
          next_r.cnt     = half_of(r.rate);
        end
      end
      ST_STOP_B: begin
        if (scl_s) begin
          if (r.cnt != 8'h00) begin
            next_r.cnt = r.cnt - CNT_STEP;
          end else begin
            next_r.st  = ST_STOP_C;
            next_r.cnt = half_of(r.rate);
          end
        end
      end
      ST_STOP_C: begin
        next_r.sda_low = 1'b0; // Stop: data rises while clock high
        if (r.cnt != 8'h00) begin
          next_r.cnt = r.cnt - CNT_STEP;
        end else begin
          next_r.st         = ST_IDLE;
          next_r.ev_stopped = 1'b1;
          next_r.stop_pend  = stop_task_in;
        end
      end
      default: begin
        next_r.st = ST_IDLE;
      end
    endcase
    // Latch a new transfer; a read request wins over a write
    if (launch) begin
      next_r.is_rx = begin_receive_task_in ? DIR_READ : DIR_WRITE;
      next_r.addr  = slave_addr_in;
      next_r.rate  = rate_sel_in;
      next_r.rem   = begin_receive_task_in ? rx_count_in : tx_count_in;
      next_r.cnt   = half_of(rate_sel_in);
    end
    // Only pull-downs: the line level is the wired AND of all parties
    for (int i = 0; i < PIN_COUNT; i++) begin
      next_r.pin_oe[i] =
        ((scl_pin_sel_in == PSEL_W'(i)) && next_r.scl_low) ||
        ((sda_pin_sel_in == PSEL_W'(i)) && next_r.sda_low);
    end
    next_r.pin_drv = '0;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      r    <= '0;
      r.st <= ST_IDLE;
    end else if (clk_en_in) begin
      r <= next_r;
    end
  end

  // Outputs straight from the state register
  assign tx_take_out             = r.tx_take;
  assign rx_data_out             = r.rx_data;
  assign rx_valid_out            = r.rx_valid;
  assign final_tx_byte_event_out = r.ev_final_tx;
  assign final_rx_byte_event_out = r.ev_final_rx;
  assign stopped_event_out       = r.ev_stopped;
  assign error_event_out         = r.ev_error;
  assign suspended_event_out     = r.ev_susp;
  assign pin_out                 = r.pin_drv;
  assign pin_oe_out              = r.pin_oe;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);

  a_clock_stretch_wait: assert property (
    (clk_en_in && r.st == ST_HIGH && !scl_s) |=> (r.st == ST_HIGH))
    else $error("Master left high phase while clock held low");
  a_data_stable_high: assert property (
    (r.st == ST_HIGH && $past(r.st) == ST_HIGH) |-> $stable(r.sda_low))
    else $error("Data line moved while clock high");
  a_dir_bit_value: assert property (
    (r.st == ST_HIGH && r.is_addr && r.bit_cnt == LAST_BIT)
      |-> (r.sda_low == !r.is_rx))
    else $error("Direction bit wrong");
  a_nack_error_raise: assert property (
    (clk_en_in && r.st == ST_HIGH && scl_s && r.cnt == 8'h00 &&
     r.bit_cnt == ACK_BIT && (!r.is_rx || r.is_addr) && sda_s)
      |=> error_event_out)
    else $error("Not-acknowledge gave no error event");
  a_rx_ack_value: assert property (
    (r.st == ST_HIGH && r.bit_cnt == ACK_BIT && r.is_rx && !r.is_addr)
      |-> (r.sda_low == (r.rem > REM_ONE)))
    else $error("Receive acknowledge wrong");
  a_no_stop_susp: assert property (
    $rose(r.st == ST_STOP_A) |-> !$past(r.susp))
    else $error("Stop taken while suspended");
  a_stopped_idle: assert property (
    stopped_event_out |-> (r.st == ST_IDLE && !r.scl_low && !r.sda_low))
    else $error("Stopped event while bus not released");
  a_rx_half_duplex: assert property (
    ((r.st == ST_HIGH) && r.is_rx && !r.is_addr && r.bit_cnt != ACK_BIT)
      |-> !r.sda_low)
    else $error("Data driven during receive bit");
  a_final_tx_take: assert property (
    final_tx_byte_event_out |-> (tx_take_out && r.rem == REM_NONE))
    else $error("Final transmit event not at last byte load");
  a_begin_starts: assert property (
    (clk_en_in && r.st == ST_IDLE && !stop_eff && start_req)
      |=> (r.st == ST_START_A))
    else $error("Begin task did not start a transfer");

endmodule // twbmc_master

`default_nettype wire

// [twbmc_slave.sv]
// Behavioural two-wire slave that answers the bus master in the bench.
// Assumes the bench resolves both pulled-up wires from all enables.
`timescale 1ns/10ps
`default_nettype none
module twbmc_slave (
  // Resolved bus lines
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  // Behaviour settings
  input  wire logic [6:0] addr_in,
  input  wire logic       nack_data_in,
  input  wire logic       stretch_en_in,
  // Pull-down enables
  output logic            scl_oe_out,
  output logic            sda_oe_out
);
  logic [7:0] shreg;
  logic [7:0] rd_byte;
  logic [7:0] got [0:15];
  logic       ack_log [0:15];
  logic       in_addr;
  logic       rd;
  logic       sel;
  logic       seen_high;
  int         bitn;
  int         n_got;
  int         n_ack;
  int         n_start;
  int         n_stop;
  int         rd_idx;
  realtime    last_rise;
  realtime    period;

  // -------------------------------------------------------------------
  // Framing
  // -------------------------------------------------------------------
  // Lines released, nothing selected before the first start
  initial begin
    {scl_oe_out, sda_oe_out, in_addr, rd, sel, seen_high} = 6'h00;
  end

  // Data moving while the clock is high marks a start or a stop
  always @(sda_in) if (scl_in === 1'b1) begin
    if (sda_in === 1'b0) begin
      n_start++;
      in_addr = 1'b1;
      bitn = 0;
      rd_idx = 0;
      seen_high = 1'b0;
    end else begin
      n_stop++;
      sel = 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // Bit engine
  // -------------------------------------------------------------------
  // Sample on the rising clock; a master NACK ends our sending
  always @(posedge scl_in) begin
    period = $realtime - last_rise;
    last_rise = $realtime;
    if (bitn < 8) shreg = {shreg[6:0], sda_in};
    else if (rd && !in_addr) begin
      ack_log[n_ack] = !sda_in;
      n_ack++;
      sel = sel && !sda_in;
    end
    seen_high = 1'b1;
  end

  // Drive well after the clock falls, as a real hold time would
  always @(negedge scl_in) if (seen_high) begin
    seen_high = 1'b0;
    bitn = (bitn == 8) ? 0 : bitn + 1;
    if (bitn == 8 && in_addr) begin
      rd  = shreg[0];
      sel = (shreg[7:1] == addr_in);
    end
    if (bitn == 8 && (in_addr || !rd)) begin
      got[n_got] = shreg;
      n_got++;
    end
    if (bitn == 0 && rd && !in_addr) rd_idx++;
    if (bitn == 0) in_addr = 1'b0;
    rd_byte = 8'h96 + rd_idx[7:0];
    #100;
    sda_oe_out = sel && ((bitn == 8) ? (in_addr || (!rd && !nack_data_in))
                                     : (rd && !in_addr && !rd_byte[7-bitn]));
    // Hold the clock low across the ack slot
    if (stretch_en_in && bitn == 8) begin
      scl_oe_out = 1'b1;
      #8000; // Longer than the slowest low half, so the master must wait
      scl_oe_out = 1'b0;
    end
  end
endmodule // twbmc_slave
`default_nettype wire

// [twbmc_master_tb.sv]
// Self-checking bench for the two-wire bus master with a slave model.
// Assumes pulled-up pins: a pin reads low when any party enables it.
`timescale 1ns/10ps
`default_nettype none
module twbmc_master_tb;
  import twbmc_pkg::*;
  localparam logic [6:0] SLV_ADDR = 7'h5b;
  logic        clk;
  logic        arst_n;
  logic [4:0]  tsk;
  logic [1:0]  rate;
  logic [6:0]  addr;
  logic [7:0]  txc, rxc, tx_data, rx_data;
  logic [4:0]  scl_sel, sda_sel;
  logic        tx_valid, tx_take, rx_valid, nack_data, stretch;
  logic        s_scl_oe, s_sda_oe;
  logic [31:0] pin_in, pout, oe;
  wire  [4:0]  evs;
  wire         scl_w = !(oe[scl_sel] | s_scl_oe);
  wire         sda_w = !(oe[sda_sel] | s_sda_oe);
  int          ev [5];
  int          n_rx, tx_idx, cyc, stray, clash, num_errors, cmp_count;
  logic [7:0]  rx_log [0:15];
  logic [7:0]  tx_buf [0:3];

  twbmc_master DUT (.ref_clk_in(clk), .arst_n_in(arst_n), .clk_en_in(1'b1),
    .begin_transmit_task_in(tsk[0]), .begin_receive_task_in(tsk[1]),
    .stop_task_in(tsk[2]), .suspend_task_in(tsk[3]),
    .resume_task_in(tsk[4]), .rate_sel_in(rate), .slave_addr_in(addr),
    .tx_count_in(txc), .rx_count_in(rxc), .scl_pin_sel_in(scl_sel),
    .sda_pin_sel_in(sda_sel), .tx_data_in(tx_data), .tx_valid_in(tx_valid),
    .tx_take_out(tx_take), .rx_data_out(rx_data), .rx_valid_out(rx_valid),
    .final_tx_byte_event_out(evs[0]), .final_rx_byte_event_out(evs[1]),
    .stopped_event_out(evs[2]), .error_event_out(evs[3]),
    .suspended_event_out(evs[4]), .pin_in(pin_in), .pin_out(pout),
    .pin_oe_out(oe));
  twbmc_slave u_slave (.scl_in(scl_w), .sda_in(sda_w), .addr_in(SLV_ADDR),
    .nack_data_in(nack_data), .stretch_en_in(stretch),
    .scl_oe_out(s_scl_oe), .sda_oe_out(s_sda_oe));

  // -------------------------------------------------------------------
  // Environment
  // -------------------------------------------------------------------
  // Wired-AND: unselected pins only see the master's own enable
  always_comb begin
    pin_in = ~oe;
    pin_in[scl_sel] = scl_w;
    pin_in[sda_sel] = sda_w;
  end

  // 25 MHz clock
  initial clk = 1'b0;
  always #20 clk = ~clk;

  // Event counting, stray pin drive, hang limit; sampled mid-cycle so the
  // registered outputs have settled after the edge that launched them
  always @(negedge clk) begin
    cyc++;
    for (int i = 0; i < 5; i++) if (evs[i] === 1'b1) ev[i]++;
    if (rx_valid === 1'b1) begin
      rx_log[n_rx] = rx_data;
      n_rx++;
    end
    if (|(oe & ~((32'h1 << scl_sel) | (32'h1 << sda_sel)))) stray++;
    if (cyc > 60000) begin
      num_errors++;
      complete_run();
    end
  end

  // Both parties pulling data at a sampling point would be a clash
  always @(posedge scl_w) if (oe[sda_sel] && s_sda_oe) clash++;

  // Byte stream: next byte offered once the previous one was taken
  always @(negedge clk) begin
    if (tx_take === 1'b1) tx_idx++;
    tx_data  = tx_buf[tx_idx[1:0]];
    tx_valid = (tx_idx < int'(txc));
  end

  // -------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One-cycle task pulse, launched off the sampling edge
  task automatic pulse(input logic [4:0] m);
    @(negedge clk) tsk = m;
    @(negedge clk) tsk = 5'h00;
  endtask

  // Bounded wait for an event; a miss shows up in the count checks
  task automatic wait_ev(input int k, input int lim);
    for (int i = 0; i < lim && ev[k] == 0; i++) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic prep(input logic [1:0] r, input logic [6:0] a,
                      input logic [4:0] cs, ds, input logic [7:0] tc, rc,
                      input logic nk, st);
    @(negedge clk);
    {rate, addr, scl_sel, sda_sel, txc, rxc} = {r, a, cs, ds, tc, rc};
    {nack_data, stretch} = {nk, st};
    for (int i = 0; i < 5; i++) ev[i] = 0;
    {n_rx, tx_idx, stray, clash} = '0;
    u_slave.n_got = 0;
    u_slave.n_ack = 0;
    u_slave.n_start = 0;
    u_slave.n_stop = 0;
  endtask

  // Clock period of the last unstretched bit against the rate
  task automatic rate_ok(input logic [7:0] half);
    check("bus period", 32'(u_slave.period >= 80.0 * half &&
          u_slave.period <= 80.0 * half + 480.0), 32'h1);
  endtask

  task automatic tail();
    check("stray pin drive", 32'(stray), 32'h0);
    check("data clash", 32'(clash), 32'h0);
  endtask

  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  task automatic write_burst();
    prep(RATE_400K, SLV_ADDR, 5'd3, 5'd17, 8'h03, 8'h00, 1'b0, 1'b0);
    pulse(5'h01);
    wait_ev(0, 4000);
    pulse(5'h04);
    wait_ev(2, 2000);
    check("final tx", 32'(ev[0]), 32'h1);
    check("stopped", 32'(ev[2]), 32'h1);
    check("error", 32'(ev[3]), 32'h0);
    check("bytes", 32'(u_slave.n_got), 32'h4);
    check("address", 32'(u_slave.got[0]), 32'hb6);
    for (int i = 0; i < 3; i++)
      check("wr byte", 32'(u_slave.got[i+1]), 32'(tx_buf[i]));
    check("starts", 32'(u_slave.n_start), 32'h1);
    check("stops", 32'(u_slave.n_stop), 32'h1);
    rate_ok(HALF_400K_CYC);
    tail();
  endtask

  task automatic read_stretch();
    prep(RATE_100K, SLV_ADDR, 5'd30, 5'd0, 8'h00, 8'h03, 1'b0, 1'b1);
    pulse(5'h02);
    wait_ev(1, 12000);
    pulse(5'h04);
    wait_ev(2, 5000);
    check("address", 32'(u_slave.got[0]), 32'hb7);
    check("final rx", 32'(ev[1]), 32'h1);
    check("rx count", 32'(n_rx), 32'h3);
    for (int i = 0; i < 3; i++) begin
      check("rx byte", 32'(rx_log[i]), 32'(8'h96 + i));
      check("master ack", 32'(u_slave.ack_log[i]), 32'(i < 2));
    end
    check("stopped", 32'(ev[2]), 32'h1);
    tail();
  endtask

  task automatic nack_error();
    prep(RATE_250K, 7'h21, 5'd7, 5'd8, 8'h01, 8'h00, 1'b0, 1'b0);
    pulse(5'h01);
    wait_ev(0, 2000);
    repeat (1500) @(negedge clk);
    check("error", 32'(ev[3]), 32'h2);
    check("stopped", 32'(ev[2]), 32'h0);
    check("stops", 32'(u_slave.n_stop), 32'h0);
    rate_ok(HALF_250K_CYC);
    pulse(5'h04);
    wait_ev(2, 1000);
    check("stopped", 32'(ev[2]), 32'h1);
    ev[2] = 0;
    pulse(5'h04);
    wait_ev(2, 3);
    check("idle stop", 32'(ev[2]), 32'h1);
    tail();
  endtask

  task automatic suspend_hold();
    prep(RATE_100K, SLV_ADDR, 5'd12, 5'd13, 8'h02, 8'h00, 1'b0, 1'b0);
    pulse(5'h01);
    pulse(5'h08);
    wait_ev(4, 4000);
    pulse(5'h04);
    repeat (1000) @(negedge clk);
    check("suspended", 32'(ev[4]), 32'h1);
    check("stopped", 32'(ev[2]), 32'h0);
    rate_ok(HALF_100K_CYC);
    pulse(5'h10);
    wait_ev(2, 1000);
    check("stopped", 32'(ev[2]), 32'h1);
    check("bytes", 32'(u_slave.n_got), 32'h1);
    tail();
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    {arst_n, tsk, rate, addr, txc, rxc, tx_valid, tx_data} = '0;
    {scl_sel, sda_sel, nack_data, stretch} = {5'd1, 5'd2, 2'b00};
    tx_buf = '{8'ha5, 8'h3c, 8'hf0, 8'h00};
    repeat (4) @(posedge clk);
    @(negedge clk) arst_n = 1'b1;
    write_burst();
    read_stretch();
    nack_error();
    suspend_hold();
    complete_run();
  end
endmodule // twbmc_master_tb
`default_nettype wire
